// ===== design/pesp_top.sv
// Purpose: Event status, interrupt control and page select registers of one port.
// Assumes: Event pulses and register strobes come from logic on ref_clk_i.
// Notes: Read data and acknowledge appear one cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
`include "pesp_cfg.svh"

module pesp_top
  import pesp_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic quality_event_i,
  input wire logic energy_event_i,
  input wire logic link_change_i,
  input wire logic speed_change_i,
  input wire logic duplex_change_i,
  input wire logic autoneg_done_i,
  input wire logic false_carrier_half_i,
  input wire logic rx_error_half_i,
  input wire logic powerdown_or_irq_pin_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic irq_o,
  output logic powerdown_or_irq_pin_o,
  output logic powerdown_or_irq_pin_oe_n_o,
  output logic powerdown_o,
  output logic [1:0] page_sel_o,
  output logic ext_bank_sel_o,
  output logic diag_bank_sel_o
);

  // ========================================================================
  // Address decode
  logic ctrl_hit;
  logic stat_hit;
  logic page_hit;
  logic stat_rd;
  logic ctrl_wr;
  logic stat_wr;
  logic page_wr;
  logic any_rd;

  assign ctrl_hit = (reg_addr_i == `PESP_ADDR_CTRL);
  assign stat_hit = (reg_addr_i == `PESP_ADDR_STAT);
  assign page_hit = (reg_addr_i == `PESP_ADDR_PAGE);
  assign stat_rd = reg_rd_i & stat_hit;
  assign ctrl_wr = reg_wr_i & ctrl_hit;
  assign stat_wr = reg_wr_i & stat_hit;
  assign page_wr = reg_wr_i & page_hit;
  assign any_rd = reg_rd_i & (ctrl_hit | stat_hit | page_hit);

  // ========================================================================
  // Pending flags
  pesp_evt_type evt;
  pesp_evt_type pend;

  // Events are recorded with no regard to any enable or gate.
  assign evt = {quality_event_i, energy_event_i, link_change_i, speed_change_i,
                duplex_change_i, autoneg_done_i, false_carrier_half_i,
                rx_error_half_i};

  genvar gi;
  generate
    for (gi = 0; gi < `PESP_NUM_EVENTS; gi++) begin : g_flag
      // Set on the event, held until the status read clears it.
      pesp_flag u_flag (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .set_i(evt[gi]),
        .clr_i(stat_rd),
        .q_o(pend[gi])
      );
    end
  endgenerate

  // ========================================================================
  // Control, enable and page registers
  logic ctrl_oe;
  logic ctrl_gate;
  logic ctrl_test;
  pesp_evt_type en;
  pesp_page_type page;
  logic next_ctrl_oe;
  logic next_ctrl_gate;
  logic next_ctrl_test;
  pesp_evt_type next_en;
  pesp_page_type next_page;

  always_comb begin
    next_ctrl_oe = ctrl_oe;
    next_ctrl_gate = ctrl_gate;
    next_ctrl_test = ctrl_test;
    next_en = en;
    next_page = page;
    if (ctrl_wr) begin
      next_ctrl_oe = reg_wdata_i[`PESP_CTRL_OE];
      next_ctrl_gate = reg_wdata_i[`PESP_CTRL_GATE];
      next_ctrl_test = reg_wdata_i[`PESP_CTRL_TEST];
    end
    if (stat_wr) begin
      // Only the enables take the write; pending bits are read-only.
      next_en = reg_wdata_i[`PESP_EN_MSB:`PESP_EN_LSB];
    end
    if (page_wr) begin
      // The reserved code is stored as written; the master must avoid it.
      next_page = reg_wdata_i[`PESP_PAGE_MSB:`PESP_PAGE_LSB];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl_oe <= 1'b0;
      ctrl_gate <= 1'b0;
      ctrl_test <= 1'b0;
      en <= `PESP_RST_BYTE;
      page <= `PESP_RST_PAGE;
    end else begin
      ctrl_oe <= next_ctrl_oe;
      ctrl_gate <= next_ctrl_gate;
      ctrl_test <= next_ctrl_test;
      en <= next_en;
      page <= next_page;
    end
  end

  // ========================================================================
  // Read port
  pesp_word_type next_rdata;
  logic next_rvalid;

  always_comb begin
    next_rdata = `PESP_RST_WORD;
    next_rvalid = any_rd;
    if (reg_rd_i) begin
      if (ctrl_hit) begin
        next_rdata = {`PESP_PAD_CTRL, ctrl_test, ctrl_gate, ctrl_oe};
      end else if (stat_hit) begin
        // The read returns the flags that the same read clears.
        next_rdata = {pend, en};
      end else if (page_hit) begin
        next_rdata = {`PESP_PAD_PAGE, page};
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= `PESP_RST_WORD;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rdata_o <= next_rdata;
      reg_rvalid_o <= next_rvalid;
    end
  end

  // ========================================================================
  // Interrupt and pin
  logic pin_meta;
  logic pin_sync;
  logic next_irq;
  logic next_pin;
  logic next_oe_n;
  logic next_powerdown;
  logic next_ext;
  logic next_diag;

  always_comb begin
    // Events need their own enable and the global gate; test bypasses both.
    next_irq = ctrl_test | (ctrl_gate & (|(pend & en)));
    // The pin is driven low for an interrupt only while configured as output.
    next_oe_n = ~ctrl_oe;
    // Gating with the enable keeps the pin level high while another agent owns the pin.
    next_pin = ~(next_irq & ctrl_oe);
    // The pin reads as power-down only while it is an input.
    next_powerdown = pin_sync & ~ctrl_oe;
    next_ext = (page == `PESP_PAGE_EXT);
    next_diag = (page == `PESP_PAGE_DIAG);
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      irq_o <= 1'b0;
      powerdown_or_irq_pin_o <= 1'b1;
      powerdown_or_irq_pin_oe_n_o <= 1'b1;
      powerdown_o <= 1'b0;
      page_sel_o <= `PESP_RST_PAGE;
      ext_bank_sel_o <= 1'b1;
      diag_bank_sel_o <= 1'b0;
    end else begin
      pin_meta <= powerdown_or_irq_pin_i;
      pin_sync <= pin_meta;
      irq_o <= next_irq;
      powerdown_or_irq_pin_o <= next_pin;
      powerdown_or_irq_pin_oe_n_o <= next_oe_n;
      powerdown_o <= next_powerdown;
      page_sel_o <= page;
      ext_bank_sel_o <= next_ext;
      diag_bank_sel_o <= next_diag;
    end
  end

  // ========================================================================
  // Assertions
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  a_pend_set: assert property ((evt != `PESP_RST_BYTE) |=> ((pend & $past(evt)) == $past(evt)))
    else $error("event did not set its pending flag");

  a_pend_hold: assert property (!stat_rd |=> ((pend & $past(pend)) == $past(pend)))
    else $error("pending flag dropped without a status read");

  a_record_ungated: assert property ((evt != `PESP_RST_BYTE) && (en == `PESP_RST_BYTE) && !ctrl_gate
      |=> ((pend & $past(evt)) == $past(evt)))
    else $error("disabled event was not recorded");

  a_read_clear: assert property (stat_rd && (evt == `PESP_RST_BYTE) |=> (pend == `PESP_RST_BYTE))
    else $error("status read did not clear the pending flags");

  a_stat_rdata: assert property (stat_rd |=> reg_rvalid_o
      && (reg_rdata_o[`PESP_PEND_MSB:`PESP_PEND_LSB] == $past(pend))
      && (reg_rdata_o[`PESP_EN_MSB:`PESP_EN_LSB] == $past(en)))
    else $error("status read data wrong");

  a_irq_event: assert property (ctrl_gate && ((pend & en) != `PESP_RST_BYTE) |=> irq_o)
    else $error("enabled pending event raised no interrupt");

  a_irq_gate: assert property (!ctrl_gate && !ctrl_test |=> !irq_o)
    else $error("interrupt raised while the gate was clear");

  a_irq_unenabled: assert property (!ctrl_test && ((pend & en) == `PESP_RST_BYTE) |=> !irq_o)
    else $error("interrupt raised with no enabled pending event");

  a_test_force: assert property (ctrl_test[*2] |=> irq_o
      && (!powerdown_or_irq_pin_o || !$past(ctrl_oe)))
    else $error("test bit did not force the interrupt");

  a_irq_release: assert property (stat_rd && !ctrl_test && !ctrl_wr && (evt == `PESP_RST_BYTE)
      |=> ##1 !irq_o)
    else $error("interrupt stayed after the flags were cleared");

  a_page_read: assert property (reg_rd_i && page_hit |=> reg_rvalid_o
      && (reg_rdata_o == {`PESP_PAD_PAGE, $past(page)}))
    else $error("page register read data wrong");

  a_page_write: assert property (page_wr |=> ##1 (page_sel_o == $past(reg_wdata_i[`PESP_PAGE_MSB:`PESP_PAGE_LSB], 2)))
    else $error("page write not seen on the page output");

  a_bank_decode: assert property ((page == `PESP_PAGE_DIAG) |=> diag_bank_sel_o && !ext_bank_sel_o)
    else $error("diagnostics bank not selected");

  a_bank_rsvd: assert property ((page != `PESP_PAGE_EXT) && (page != `PESP_PAGE_DIAG)
      |=> !diag_bank_sel_o && !ext_bank_sel_o)
    else $error("reserved page selected a bank");

  a_pin_dir: assert property (!ctrl_oe |=> powerdown_or_irq_pin_oe_n_o && powerdown_or_irq_pin_o)
    else $error("pin driven while configured as input");

  a_pin_drive: assert property (ctrl_oe |=> !powerdown_or_irq_pin_oe_n_o && !powerdown_o)
    else $error("pin not driven while configured as output");

  a_pin_level: assert property (ctrl_oe && !ctrl_test && ((pend & en) == `PESP_RST_BYTE)
      |=> powerdown_or_irq_pin_o)
    else $error("pin driven low with no interrupt");

  a_ctrl_read: assert property (reg_rd_i && ctrl_hit |=> reg_rvalid_o
      && (reg_rdata_o == {`PESP_PAD_CTRL, $past(ctrl_test),
                          $past(ctrl_gate), $past(ctrl_oe)}))
    else $error("control register read data wrong");

  a_ctrl_hold: assert property (!ctrl_wr |=> $stable(ctrl_test)
      && $stable(ctrl_gate) && $stable(ctrl_oe))
    else $error("control bits changed without a write");

  a_en_write: assert property (stat_wr |=> (en == $past(reg_wdata_i[`PESP_EN_MSB:`PESP_EN_LSB])))
    else $error("enable write not stored");

  a_pend_rdonly: assert property (stat_wr && !stat_rd && (evt == `PESP_RST_BYTE)
      |=> (pend == $past(pend)))
    else $error("status write changed the pending flags");

  a_page_hold: assert property (!page_wr |=> (page == $past(page)))
    else $error("page field changed without a write");

  a_bank_ext: assert property ((page == `PESP_PAGE_EXT) |=> ext_bank_sel_o && !diag_bank_sel_o)
    else $error("extended bank not selected");

  a_rd_unmapped: assert property (reg_rd_i && !ctrl_hit && !stat_hit && !page_hit
      |=> !reg_rvalid_o)
    else $error("foreign address answered");

  c_read_pending: cover property (stat_rd && (pend != `PESP_RST_BYTE));
  c_set_on_clear: cover property (stat_rd && (evt != `PESP_RST_BYTE));
  c_test_irq: cover property (ctrl_test && ctrl_oe ##1 irq_o);
  c_event_irq: cover property (ctrl_gate && ((pend & en) != `PESP_RST_BYTE) ##1 irq_o);
  c_diag_page: cover property (page_wr ##2 diag_bank_sel_o);

endmodule

`default_nettype wire

// ===== design/pesp_cfg.svh
// Functional notes
// - Each event sets its sticky pending flag; it holds until the status register is read.
// - An event whose own enable bit is set raises the interrupt.
// - Event interrupts also need the global gate in the interrupt control register.
// - Pending flags are recorded whether or not any enable or gate is set.
// - Status bit 15 is link quality pending; reset 0, read-only, cleared by read.
// - Status bit 14 is energy detect pending; reset 0, read-only, cleared by read.
// - Status bit 13 is link change pending; reset 0, read-only, cleared by read.
// - Status bit 12 is speed change pending; reset 0, read-only, cleared by read.
// - Status bit 11 is duplex change pending; reset 0, read-only, cleared by read.
// - Status bit 10 is auto-negotiation done pending; reset 0, read-only, cleared by read.
// - Status bit 9 is false carrier counter half-full; reset 0, read-only, read-clear.
// - Status bit 8 is receive error counter half-full; reset 0, read-only, read-clear.
// - Status bits 7:0 are read-write per-event enables, reset 0, same event order.
// - Page field bits 1:0, reset 0, selects the bank seen at addresses 14h to 1Fh.
// - Page 0 is the extended bank, 2 the diagnostics bank, 1 is reserved.
// - Page register bits 15:2 ignore writes and read as zero.
// - Global gate bit, reset 0, blocks all event interrupts while clear.
// - Test bit forces the interrupt continuously while it stays set.
// - Output-enable bit makes the shared pin an interrupt output; clear means power-down input.
//
// Purpose: Register addresses, field positions and reset values of the event block.
// Assumes: A 5-bit management register address and 16-bit register data.
// Notes: Event index 7 down to 0 follows the enable bit order of the status register.
`ifndef PESP_CFG_SVH
`define PESP_CFG_SVH

// ==========================================================================
// Register addresses
`define PESP_ADDR_CTRL 5'h11
`define PESP_ADDR_STAT 5'h12
`define PESP_ADDR_PAGE 5'h13

// ==========================================================================
// Field positions
`define PESP_CTRL_OE 0
`define PESP_CTRL_GATE 1
`define PESP_CTRL_TEST 2
`define PESP_PEND_MSB 15
`define PESP_PEND_LSB 8
`define PESP_EN_MSB 7
`define PESP_EN_LSB 0
`define PESP_PAGE_MSB 1
`define PESP_PAGE_LSB 0
`define PESP_NUM_EVENTS 8

// ==========================================================================
// Reset values and page codes
`define PESP_RST_WORD 16'h0000
`define PESP_RST_BYTE 8'h00
`define PESP_RST_PAGE 2'h0
`define PESP_PAGE_EXT 2'h0
`define PESP_PAGE_RSVD 2'h1
`define PESP_PAGE_DIAG 2'h2
`define PESP_PAD_CTRL 13'h0000
`define PESP_PAD_PAGE 14'h0000

`endif

// ===== design/pesp_pkg.sv
// Purpose: Shared types of the event status and page select block.
// Assumes: The configuration header supplies the event count; the other widths are fixed here.
// Notes: Types only; no logic lives here.
`include "pesp_cfg.svh"

package pesp_pkg;

  // ========================================================================
  // Data types
  typedef logic [15:0] pesp_word_type;
  typedef logic [`PESP_NUM_EVENTS-1:0] pesp_evt_type;
  typedef logic [4:0] pesp_addr_type;
  typedef logic [1:0] pesp_page_type;

endpackage

// ===== design/pesp_flag.sv
// Purpose: One sticky pending flag with set and clear.
// Assumes: Set and clear come from logic on the same clock.
// Notes: A set in the clearing cycle wins, so no event is lost.
`timescale 1ns/1ps
`default_nettype none

module pesp_flag (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic q_o
);

  // ========================================================================
  // Flag state
  logic next_q;

  always_comb begin
    next_q = set_i | (q_o & ~clr_i);
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q_o <= 1'b0;
    end else begin
      q_o <= next_q;
    end
  end

endmodule

`default_nettype wire

// ===== verification/pesp_mgmt_master.sv
// Purpose: Management master model that reads and writes the event block registers.
// Assumes: One strobe cycle per access; read data stands in the cycle after the strobe.
// Notes: Idle address and data show the inverse of the last value, never a stale copy.
`timescale 1ns/1ps
`default_nettype none

module pesp_mgmt_master
  import pesp_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic [15:0] reg_rdata_i,
  input wire logic reg_rvalid_i,
  output logic [4:0] reg_addr_o,
  output logic reg_rd_o,
  output logic reg_wr_o,
  output logic [15:0] reg_wdata_o
);
  // ==========================================================================
  // Idle state
  initial begin
    reg_addr_o = 5'h00;
    reg_rd_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_wdata_o = 16'h0000;
  end

  // ==========================================================================
  // Accesses
  // Page code 1 is never asked of this model by the bench.
  task automatic wr(input pesp_addr_type a, input pesp_word_type d);
    @(posedge ref_clk_i);
    #1;
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(posedge ref_clk_i);
    #1;
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask

  task automatic rd(input pesp_addr_type a, output pesp_word_type d, output logic v);
    @(posedge ref_clk_i);
    #1;
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(posedge ref_clk_i);
    #1;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    d = reg_rdata_i;
    v = reg_rvalid_i;
  endtask
endmodule

`default_nettype wire

// ===== verification/test_phy_event_status_and_page_select.sv
// Purpose: Self-checking bench of the event status, control and page registers.
// Assumes: Interrupt and pin outputs lag a register change or event by two edges.
// Notes: Pin level is resolved here from the block's enable and the far-side level.
`timescale 1ns/1ps
`default_nettype none

module test_phy_event_status_and_page_select;
  import pesp_pkg::*;
  logic ref_clk_i;
  logic rst_i;
  logic [4:0] addr;
  logic rd, wr, rvalid, pin_ext, pin_wire, irq, pin_o, oe_n, pwd, ext, diag, v;
  logic [15:0] wdata, rdata;
  logic [1:0] page;
  pesp_evt_type ev;
  pesp_word_type d;
  int n_fail;
  int checks;
  int k;

  assign pin_wire = oe_n ? pin_ext : pin_o;

  // ==========================================================================
  // Clock and instances
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  pesp_mgmt_master m (.ref_clk_i(ref_clk_i), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid),
    .reg_addr_o(addr), .reg_rd_o(rd), .reg_wr_o(wr), .reg_wdata_o(wdata));

  pesp_top DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_rd_i(rd),
    .reg_wr_i(wr), .reg_wdata_i(wdata), .quality_event_i(ev[7]), .energy_event_i(ev[6]),
    .link_change_i(ev[5]), .speed_change_i(ev[4]), .duplex_change_i(ev[3]),
    .autoneg_done_i(ev[2]), .false_carrier_half_i(ev[1]), .rx_error_half_i(ev[0]),
    .powerdown_or_irq_pin_i(pin_wire), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .irq_o(irq), .powerdown_or_irq_pin_o(pin_o), .powerdown_or_irq_pin_oe_n_o(oe_n),
    .powerdown_o(pwd), .page_sel_o(page), .ext_bank_sel_o(ext), .diag_bank_sel_o(diag));

  // ==========================================================================
  // Helpers
  task automatic chk_word(input pesp_word_type act, input pesp_word_type exp);
    checks++;
    if (act !== exp) begin
      n_fail++;
      $display("ERROR %0t word %h expected %h", $time, act, exp);
    end
  endtask

  task automatic chk_bit(input logic act, input logic exp);
    checks++;
    if (act !== exp) begin
      n_fail++;
      $display("ERROR %0t bit %b expected %b", $time, act, exp);
    end
  endtask

  task automatic rchk(input pesp_addr_type a, input pesp_word_type exp);
    m.rd(a, d, v);
    chk_bit(v, 1'b1);
    chk_word(d, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic pulse(input int i);
    @(posedge ref_clk_i);
    #1;
    ev[i] = 1'b1;
    @(posedge ref_clk_i);
    #1;
    ev = 8'h00;
  endtask

  task automatic results();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #40000;
    n_fail++;
    results();
  end

  // ==========================================================================
  // Tests
  initial begin
    rst_i = 1'b1;
    ev = 8'h00;
    pin_ext = 1'b0;
    n_fail = 0;
    checks = 0;
    cyc(3);
    rst_i = 1'b0;
    chk_bit(irq, 1'b0);
    chk_bit(oe_n, 1'b1);
    chk_bit(ext, 1'b1);
    rchk(5'h11, 16'h0000);
    rchk(5'h12, 16'h0000);
    rchk(5'h13, 16'h0000);
    m.rd(5'h14, d, v);
    chk_bit(v, 1'b0);
    $display("test reset done");
    m.wr(5'h12, 16'hffff);
    rchk(5'h12, 16'h00ff);
    m.wr(5'h12, 16'h0000);
    for (k = 0; k < 8; k++) begin
      pulse(k);
      cyc(2);
      chk_bit(irq, 1'b0);
      rchk(5'h12, 16'h0100 << k);
      rchk(5'h12, 16'h0000);
    end
    $display("test sticky done");
    m.wr(5'h11, 16'h0003);
    for (k = 0; k < 8; k++) begin
      m.wr(5'h12, 16'h0001 << k);
      pulse((k + 1) % 8);
      cyc(2);
      chk_bit(irq, 1'b0);
      pulse(k);
      cyc(1);
      chk_bit(irq, 1'b1);
      chk_bit(pin_o, 1'b0);
      rchk(5'h12, (16'h0101 << k) | (16'h0100 << ((k + 1) % 8)));
      cyc(1);
      chk_bit(irq, 1'b0);
    end
    $display("test enable done");
    m.wr(5'h11, 16'h0001);
    m.wr(5'h12, 16'h00ff);
    pulse(7);
    cyc(3);
    chk_bit(irq, 1'b0);
    rchk(5'h12, 16'h80ff);
    m.wr(5'h11, 16'h0005);
    cyc(1);
    chk_bit(irq, 1'b1);
    cyc(6);
    chk_bit(irq, 1'b1);
    m.wr(5'h11, 16'hfff9);
    rchk(5'h11, 16'h0001);
    cyc(1);
    chk_bit(irq, 1'b0);
    $display("test gate done");
    m.wr(5'h11, 16'h0000);
    pin_ext = 1'b1;
    cyc(4);
    chk_bit(oe_n, 1'b1);
    chk_bit(pwd, 1'b1);
    m.wr(5'h11, 16'h0001);
    cyc(4);
    chk_bit(oe_n, 1'b0);
    chk_bit(pwd, 1'b0);
    $display("test pin done");
    m.wr(5'h13, 16'hfffe);
    cyc(1);
    rchk(5'h13, 16'h0002);
    chk_bit(diag, 1'b1);
    chk_bit(ext, 1'b0);
    chk_word({14'h0000, page}, 16'h0002);
    m.wr(5'h13, 16'h0003);
    cyc(1);
    rchk(5'h13, 16'h0003);
    chk_bit(ext, 1'b0);
    chk_bit(diag, 1'b0);
    m.wr(5'h13, 16'hfffc);
    cyc(1);
    rchk(5'h13, 16'h0000);
    chk_bit(ext, 1'b1);
    chk_bit(diag, 1'b0);
    $display("test page done");
    results();
  end
endmodule

`default_nettype wire
